// >>> rtl/atc_host.sv
// Host end: takes commands over a classic Wishbone slave and runs I/O port
// cycles on the device, with settling waits and board detection.
// Assumes a single clock and a synchronous active-high reset.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module atc_host #(
    parameter int DETECT_CYCLES = atc_pkg::DETECT_CYC_DEFAULT
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    output var  logic        irq_o,
    atc_io_if.host           io
);

    if (DETECT_CYCLES < 1 || DETECT_CYCLES > 65535) begin : g_bad_timeout
        $error("DETECT_CYCLES must lie in 1..65535");
    end

    typedef enum logic [3:0] {
        H_IDLE, H_WR, H_RD, H_RDCAP, H_SETTLE, H_DMODE, H_DGAP, H_DTRIG, H_DRD, H_DWAIT, H_DCHK
    } atc_hst_st_t;

    typedef struct packed {
        logic                     ack;
        logic [31:0]              dat;
        atc_hst_st_t              st;
        logic [1:0]               res;
        logic [7:0]               rd_data;
        logic [15:0]              cnt;
        logic [atc_pkg::INT_W-1:0] int_st;
        logic [atc_pkg::INT_W-1:0] mask;
        logic                     irq;
        logic                     wr;
        logic                     rd;
        logic [3:0]               addr;
        logic [7:0]               wdata;
        logic                     irq_prev;
    } atc_hst_state_t;

    atc_hst_state_t s;
    atc_hst_state_t next_s;
    logic           wb_req;
    logic           wb_wr;
    logic [31:0]    cmd;

    function automatic logic [15:0] settle_cycles(input logic [3:0] a, input logic [7:0] d,
                                                  input logic [1:0] r);
        logic [15:0] c;
        c = 16'h0000;
        if (a == atc_pkg::OFS_GAIN) begin
            case (d[1:0])
                2'h0:    c = 16'(atc_pkg::GAIN_SETTLE_X1_CYC);
                2'h1:    c = 16'(atc_pkg::GAIN_SETTLE_X2_CYC);
                2'h2:    c = 16'(atc_pkg::GAIN_SETTLE_X4_CYC);
                default: c = 16'(atc_pkg::GAIN_SETTLE_X8_CYC);
            endcase
        end else if (a == atc_pkg::OFS_CHAN) begin
            case (r)
                2'h0:    c = 16'(atc_pkg::MUX_SETTLE_R0_CYC);
                2'h1:    c = 16'(atc_pkg::MUX_SETTLE_R1_CYC);
                2'h2:    c = 16'(atc_pkg::MUX_SETTLE_R2_CYC);
                default: c = 16'(atc_pkg::MUX_SETTLE_R3_CYC);
            endcase
        end
        return c;
    endfunction : settle_cycles

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_s = s;
        cmd    = wb_dat_i;
        wb_req = wb_cyc_i && wb_stb_i;
        wb_wr  = wb_req && s.ack && wb_we_i && (wb_sel_i == 4'hf);
        next_s.ack = wb_req && !s.ack;
        next_s.wr  = 1'b0;
        next_s.rd  = 1'b0;
        next_s.irq_prev = io.irq;
        if (wb_req && !s.ack) begin
            case (wb_adr_i)
                atc_pkg::WB_STAT: next_s.dat = {16'h0000, s.rd_data, 7'h00, s.st != H_IDLE};
                atc_pkg::WB_INT:  next_s.dat = {28'h0000000, s.int_st};
                atc_pkg::WB_MASK: next_s.dat = {28'h0000000, s.mask};
                default:          next_s.dat = 32'h00000000;
            endcase
        end
        if (wb_wr && wb_adr_i == atc_pkg::WB_INT) begin
            next_s.int_st = s.int_st & ~wb_dat_i[atc_pkg::INT_W-1:0];
        end
        if (wb_wr && wb_adr_i == atc_pkg::WB_MASK) begin
            next_s.mask = wb_dat_i[atc_pkg::INT_W-1:0];
        end
        if (io.irq && !s.irq_prev) begin
            next_s.int_st[atc_pkg::INT_DEVIRQ] = 1'b1;
        end
        if (s.cnt != 16'h0000) begin
            next_s.cnt = s.cnt - 16'h0001;
        end

        case (s.st)
            H_IDLE: begin
                if (wb_wr && wb_adr_i == atc_pkg::WB_CMD) begin
                    next_s.addr  = cmd[atc_pkg::CMD_ADDR_LSB +: 4];
                    next_s.wdata = cmd[atc_pkg::CMD_DATA_LSB +: 8];
                    next_s.res   = cmd[atc_pkg::CMD_RES_LSB +: 2];
                    if (cmd[atc_pkg::CMD_DETECT_BIT]) begin
                        next_s.st = H_DMODE;
                    end else if (cmd[atc_pkg::CMD_WRITE_BIT]) begin
                        next_s.wr = 1'b1;
                        next_s.st = H_WR;
                    end else begin
                        next_s.rd = 1'b1;
                        next_s.st = H_RD;
                    end
                end
            end
            H_WR: begin
                next_s.cnt = settle_cycles(s.addr, s.wdata, s.res);
                if (settle_cycles(s.addr, s.wdata, s.res) == 16'h0000) begin
                    next_s.st = H_IDLE;
                    next_s.int_st[atc_pkg::INT_DONE] = 1'b1;
                end else begin
                    next_s.st = H_SETTLE;
                end
            end
            H_SETTLE: begin
                if (s.cnt == 16'h0001) begin
                    next_s.st = H_IDLE;
                    next_s.int_st[atc_pkg::INT_DONE] = 1'b1;
                end
            end
            H_RD: begin
                next_s.st = H_RDCAP;
            end
            H_RDCAP: begin
                next_s.rd_data = io.rdata;
                next_s.st      = H_IDLE;
                next_s.int_st[atc_pkg::INT_DONE] = 1'b1;
            end
            H_DMODE: begin
                next_s.wr    = 1'b1;
                next_s.addr  = atc_pkg::OFS_MODE;
                next_s.wdata = {5'h00, atc_pkg::MODE_SW_POLL};
                next_s.st    = H_DGAP;
            end
            // One idle cycle keeps the two writes apart as separate strobes.
            H_DGAP: begin
                next_s.st = H_DTRIG;
            end
            H_DTRIG: begin
                next_s.wr    = 1'b1;
                next_s.addr  = atc_pkg::OFS_SWTRIG;
                next_s.cnt   = 16'(DETECT_CYCLES);
                next_s.st    = H_DRD;
            end
            H_DRD: begin
                next_s.rd   = 1'b1;
                next_s.addr = atc_pkg::OFS_READY;
                next_s.st   = H_DWAIT;
            end
            H_DWAIT: begin
                next_s.st = H_DCHK;
            end
            H_DCHK: begin
                next_s.rd_data = io.rdata;
                if (!io.rdata[atc_pkg::READY_BIT]) begin
                    next_s.st = H_IDLE;
                    next_s.int_st[atc_pkg::INT_DETOK]  = 1'b1;
                    next_s.int_st[atc_pkg::INT_DONE]   = 1'b1;
                end else if (s.cnt == 16'h0000) begin
                    next_s.st = H_IDLE;
                    next_s.int_st[atc_pkg::INT_DETFAIL] = 1'b1;
                    next_s.int_st[atc_pkg::INT_DONE]    = 1'b1;
                end else begin
                    next_s.st = H_DRD;
                end
            end
            default: next_s.st = H_IDLE;
        endcase
        next_s.irq = |(next_s.int_st & next_s.mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s    <= '0;
            s.st <= H_IDLE;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.dat;
    assign irq_o    = s.irq;
    assign io.wr    = s.wr;
    assign io.rd    = s.rd;
    assign io.addr  = s.addr;
    assign io.wdata = s.wdata;

endmodule : atc_host
`default_nettype wire

// >>> include/atc_pkg.sv
// Shared constants and types for the converter trigger and transfer control block.
// Assumes a single 10 MHz clock shared by the device end and the host end.
package atc_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;

    // A least time rounds up to whole cycles and never comes to less than one.
    function automatic int atc_us_to_cycles(input int us);
        int c;
        c = (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : atc_us_to_cycles

    localparam int GAIN_SETTLE_X1_US  = 23;
    localparam int GAIN_SETTLE_X2_US  = 23;
    localparam int GAIN_SETTLE_X4_US  = 25;
    localparam int GAIN_SETTLE_X8_US  = 28;
    localparam int MUX_SETTLE_R0_US   = 3;
    localparam int MUX_SETTLE_R1_US   = 5;
    localparam int MUX_SETTLE_R2_US   = 10;
    localparam int MUX_SETTLE_R3_US   = 100;
    localparam int GAIN_SETTLE_X1_CYC = atc_us_to_cycles(GAIN_SETTLE_X1_US);
    localparam int GAIN_SETTLE_X2_CYC = atc_us_to_cycles(GAIN_SETTLE_X2_US);
    localparam int GAIN_SETTLE_X4_CYC = atc_us_to_cycles(GAIN_SETTLE_X4_US);
    localparam int GAIN_SETTLE_X8_CYC = atc_us_to_cycles(GAIN_SETTLE_X8_US);
    localparam int MUX_SETTLE_R0_CYC  = atc_us_to_cycles(MUX_SETTLE_R0_US);
    localparam int MUX_SETTLE_R1_CYC  = atc_us_to_cycles(MUX_SETTLE_R1_US);
    localparam int MUX_SETTLE_R2_CYC  = atc_us_to_cycles(MUX_SETTLE_R2_US);
    localparam int MUX_SETTLE_R3_CYC  = atc_us_to_cycles(MUX_SETTLE_R3_US);
    localparam int DETECT_CYC_DEFAULT = 2000;

    // ************************************************************
    // Device port map
    // ************************************************************
    localparam logic [3:0] OFS_DATA_LO = 4'h4;
    localparam logic [3:0] OFS_DATA_HI = 4'h5;
    localparam logic [3:0] OFS_READY   = 4'h8;
    localparam logic [3:0] OFS_GAIN    = 4'h9;
    localparam logic [3:0] OFS_CHAN    = 4'ha;
    localparam logic [3:0] OFS_MODE    = 4'hb;
    localparam logic [3:0] OFS_SWTRIG  = 4'hc;
    localparam int         READY_BIT   = 4;

    localparam logic [2:0] MODE_OFF       = 3'h0;
    localparam logic [2:0] MODE_SW_POLL   = 3'h1;
    localparam logic [2:0] MODE_PACER_DMA = 3'h2;
    localparam logic [2:0] MODE_PACER_IRQ = 3'h6;

    localparam logic [1:0] GAIN_RESET    = 2'h0;
    localparam logic [3:0] CHAN_RESET    = 4'h0;
    localparam logic [2:0] MODE_RESET    = 3'h0;
    localparam logic       NOT_RDY_RESET = 1'b1;
    localparam logic [1:0] DMA_PULSES    = 2'h3;

    typedef struct packed {
        logic sw;
        logic pacer;
        logic ext;
        logic poll;
        logic irq;
        logic dma;
    } atc_paths_t;

    // Undefined codes enable nothing; external source never offers software start.
    function automatic atc_paths_t atc_decode(input logic [2:0] mode, input logic ext_sel);
        atc_paths_t p;
        p = '0;
        case (mode)
            MODE_SW_POLL: begin
                p.sw   = !ext_sel;
                p.poll = !ext_sel;
            end
            MODE_PACER_DMA: begin
                p.pacer = !ext_sel;
                p.ext   = ext_sel;
                p.dma   = 1'b1;
            end
            MODE_PACER_IRQ: begin
                p.pacer = !ext_sel;
                p.ext   = ext_sel;
                p.poll  = 1'b1;
                p.irq   = 1'b1;
            end
            default: p = '0;
        endcase
        return p;
    endfunction : atc_decode

    // ************************************************************
    // Host command registers
    // ************************************************************
    localparam logic [7:0] WB_CMD   = 8'h00;
    localparam logic [7:0] WB_STAT  = 8'h04;
    localparam logic [7:0] WB_INT   = 8'h08;
    localparam logic [7:0] WB_MASK  = 8'h0c;
    localparam int CMD_ADDR_LSB     = 0;
    localparam int CMD_DATA_LSB     = 8;
    localparam int CMD_WRITE_BIT    = 16;
    localparam int CMD_DETECT_BIT   = 17;
    localparam int CMD_RES_LSB      = 18;
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_RDATA_LSB   = 8;
    localparam int INT_DONE         = 0;
    localparam int INT_DEVIRQ       = 1;
    localparam int INT_DETFAIL      = 2;
    localparam int INT_DETOK        = 3;
    localparam int INT_W            = 4;

endpackage : atc_pkg

// >>> include/atc_io_if.sv
// I/O port cycle carrier between the host end and the device end.
// Assumes both ends run on the same clock; strobes are one cycle per access.
`timescale 1ns/1ps
`default_nettype none
interface atc_io_if;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       irq;
    logic       dma_req;

    modport device (input addr, input wdata, input wr, input rd,
                    output rdata, output irq, output dma_req);
    modport host   (output addr, output wdata, output wr, output rd,
                    input rdata, input irq, input dma_req);
endinterface : atc_io_if
`default_nettype wire

// >>> rtl/atc_device.sv
// Device end: gain, channel and mode registers, trigger stage and transfer stage.
// Assumes host I/O strobes, pacer tick, external trigger and converter done are
// synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module atc_device (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    atc_io_if.device         io,
    input  wire logic        trigger_source_jumper_i,
    input  wire logic        differential_i,
    input  wire logic        pacer_tick_i,
    input  wire logic        ext_trig_i,
    input  wire logic        conv_done_i,
    input  wire logic [15:0] conv_data_i,
    output var  logic        conv_start_o,
    output var  logic        gain_code_high_bit_o,
    output var  logic        gain_code_low_bit_o,
    output var  logic [3:0]  mux_sel_o
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [1:0]  gain;
        logic [3:0]  chan;
        logic [2:0]  mode;
        logic [3:0]  mux;
        logic        busy;
        logic        not_ready;
        logic [15:0] result;
        logic        irq_flag;
        logic [1:0]  dma_left;
        logic        start;
        logic [7:0]  rdata;
        logic        ext_prev;
    } atc_dev_state_t;

    atc_dev_state_t s;
    atc_dev_state_t next_s;
    atc_pkg::atc_paths_t paths;
    logic trig;
    logic sw_write;

    // The two requests per result come from bit 0 of a count down from three.
    if (atc_pkg::DMA_PULSES != 2'h3) begin : g_bad_dma_count
        $error("DMA_PULSES must be 3 to give two requests per result");
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_s   = s;
        next_s.start    = 1'b0;
        next_s.ext_prev = ext_trig_i;
        paths    = atc_pkg::atc_decode(s.mode, trigger_source_jumper_i);
        sw_write = io.wr && (io.addr == atc_pkg::OFS_SWTRIG);

        if (io.wr) begin
            case (io.addr)
                atc_pkg::OFS_GAIN: begin
                    next_s.gain = io.wdata[1:0];
                end
                atc_pkg::OFS_CHAN: begin
                    next_s.chan = io.wdata[3:0];
                end
                atc_pkg::OFS_MODE: begin
                    next_s.mode = io.wdata[2:0];
                end
                atc_pkg::OFS_READY: begin
                    next_s.irq_flag = 1'b0;
                end
                atc_pkg::OFS_SWTRIG: begin
                    // The byte itself is ignored; only the strobe starts a conversion.
                    next_s.mode = s.mode;
                end
                default: begin
                    next_s.mode = next_s.mode;
                end
            endcase
        end

        // ************************************************************
        // Trigger stage
        // ************************************************************
        // A start that lands while a conversion runs is dropped, since the
        // converter cannot take a second start before it reports done.
        trig = (sw_write && paths.sw)
             || (pacer_tick_i && paths.pacer)
             || (ext_trig_i && !s.ext_prev && paths.ext);
        if (trig && !s.busy) begin
            next_s.start     = 1'b1;
            next_s.busy      = 1'b1;
            next_s.not_ready = 1'b1;
        end

        // ************************************************************
        // Transfer stage
        // ************************************************************
        if (s.dma_left != 2'h0) begin
            next_s.dma_left = s.dma_left - 2'h1;
        end

        // The completion is handled after the clear so that it wins over it.
        if (s.busy && conv_done_i) begin
            next_s.busy      = 1'b0;
            next_s.not_ready = 1'b0;
            next_s.result    = conv_data_i;
            if (paths.irq) begin
                next_s.irq_flag = 1'b1;
            end
            if (paths.dma) begin
                next_s.dma_left = atc_pkg::DMA_PULSES;
            end
        end

        if (differential_i) begin
            next_s.mux = {1'b0, next_s.chan[2:0]};
        end else begin
            next_s.mux = next_s.chan;
        end

        if (io.rd) begin
            case (io.addr)
                atc_pkg::OFS_DATA_LO: begin
                    next_s.rdata = s.result[7:0];
                end
                atc_pkg::OFS_DATA_HI: begin
                    next_s.rdata = s.result[15:8];
                end
                atc_pkg::OFS_READY: begin
                    next_s.rdata = 8'h00;
                    next_s.rdata[atc_pkg::READY_BIT] = s.not_ready;
                end
                default: begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s           <= '0;
            s.gain      <= atc_pkg::GAIN_RESET;
            s.chan      <= atc_pkg::CHAN_RESET;
            s.mode      <= atc_pkg::MODE_RESET;
            s.not_ready <= atc_pkg::NOT_RDY_RESET;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // The pair of DMA requests falls on alternate cycles: one per result byte.
    assign io.dma_req             = s.dma_left[0];
    assign io.irq                 = s.irq_flag;
    assign io.rdata               = s.rdata;
    assign conv_start_o           = s.start;
    assign gain_code_high_bit_o   = s.gain[1];
    assign gain_code_low_bit_o    = s.gain[0];
    assign mux_sel_o              = s.mux;

endmodule : atc_device
`default_nettype wire

// >>> verification/atc_io_assertions.sv
// Checker on the I/O carrier between the host end and the device end.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module atc_io_assertions (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [3:0] addr,
    input  wire logic       wr,
    input  wire logic       rd,
    input  wire logic [7:0] rdata,
    input  wire logic       irq,
    input  wire logic       dma_req
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_wr_one_cycle: assert property (wr |=> !wr)
        else $error("write strobe longer than one cycle");
    a_rd_spaced: assert property (rd |=> !rd [*2])
        else $error("read strobes closer than three cycles");
    a_strobe_excl: assert property (!(wr && rd))
        else $error("read and write strobes together");
    a_irq_holds: assert property (irq && !(wr && addr == 4'h8) |=> irq)
        else $error("interrupt dropped without a clearing write");
    a_irq_not_dma: assert property ($rose(irq) |-> !dma_req)
        else $error("interrupt and transfer request together");
    a_dma_single: assert property (dma_req |=> !dma_req)
        else $error("transfer request longer than one cycle");
    a_dma_pair: assert property ($rose(dma_req) && !$past(dma_req, 2) |=> !dma_req ##1 dma_req)
        else $error("second transfer request missing");
    a_rdata_hold: assert property ($changed(rdata) |-> $past(rd))
        else $error("read data changed without a read");
endmodule : atc_io_assertions
`default_nettype wire

// >>> verification/atc_tb_top.sv
// Bench joining the host end to the device end, with a small converter model.
// Assumes the host command map of the package and one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module atc_tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, we = 1'b0, jmp = 1'b0, diff = 1'b0;
    logic        tick = 1'b0, ext = 1'b0, done = 1'b0, rsp = 1'b1, ce = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat, rd_q;
    logic        ack, irq_o, start, gh, gl;
    logic [3:0]  mux, dly = 4'h0;
    int          num_errors = 0, checked = 0, cycles = 0, nstart = 0, ndma = 0;
    atc_io_if io_c ();
    atc_device u_atc_device (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .io(io_c),
        .trigger_source_jumper_i(jmp), .differential_i(diff), .pacer_tick_i(tick),
        .ext_trig_i(ext), .conv_done_i(done), .conv_data_i(16'ha55a), .conv_start_o(start),
        .gain_code_high_bit_o(gh), .gain_code_low_bit_o(gl), .mux_sel_o(mux));
    atc_host #(.DETECT_CYCLES(50)) u_atc_host (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq_o), .io(io_c));
    atc_io_assertions u_atc_io_assertions (.clk_i(clk_i), .rst_i(rst_i), .addr(io_c.addr),
        .wr(io_c.wr), .rd(io_c.rd), .rdata(io_c.rdata), .irq(io_c.irq), .dma_req(io_c.dma_req));
    always #50 clk_i = ~clk_i;

    // ****************************************
    // Converter model and hang guard
    // ****************************************
    // The converter answers five cycles after a start; rsp low makes it stay silent.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        done <= dly == 4'h1;
        if (dly != 4'h0) dly <= dly - 4'h1;
        if (start === 1'b1) nstart <= nstart + 1;
        if (start === 1'b1 && rsp) dly <= 4'h5;
        if (io_c.dma_req === 1'b1) ndma <= ndma + 1;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rd_q = rdat;
        cyc <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic cmd(input logic w, input logic [3:0] p, input logic [7:0] d,
                       input logic [1:0] r);
        wb(1'b1, 8'h00, {12'h0, r, 1'b0, w, d, 4'h0, p});
    endtask : cmd
    task automatic idle();
        do wb(1'b0, 8'h04, 32'h0); while (rd_q[0] !== 1'b0);
    endtask : idle
    task automatic op(input logic w, input logic [3:0] p, input logic [7:0] d);
        cmd(w, p, d, 2'h0);
        idle();
    endtask : op
    task automatic kick(input logic e);
        if (e) ext <= 1'b1;
        else tick <= 1'b1;
        @(posedge clk_i);
        ext <= 1'b0;
        tick <= 1'b0;
        repeat (12) @(posedge clk_i);
    endtask : kick

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_basic();
        wb(1'b0, 8'h10, 32'h0);
        check(rd_q, 32'h0);
        op(1'b0, 4'h8, 8'h00);
        check(32'(rd_q[12]), 32'h1);
        check(32'({gh, gl, mux}), 32'h0);
        for (int g = 0; g < 4; g++) begin
            cmd(1'b1, 4'h9, 8'hfc | 8'(g), 2'h0);
            repeat (200) @(posedge clk_i);
            wb(1'b0, 8'h04, 32'h0);
            check(32'(rd_q[0]), 32'h1);
            idle();
            check(32'({gh, gl}), 32'(g));
        end
        cmd(1'b1, 4'ha, 8'hf5, 2'h3);
        repeat (900) @(posedge clk_i);
        wb(1'b0, 8'h04, 32'h0);
        check(32'(rd_q[0]), 32'h1);
        idle();
        check(32'(mux), 32'h5);
        diff <= 1'b1;
        op(1'b1, 4'ha, 8'h0b);
        check(32'(mux), 32'h3);
        diff <= 1'b0;
        repeat (2) @(posedge clk_i);
        check(32'(mux), 32'hb);
        ce <= 1'b0;
        diff <= 1'b1;
        repeat (3) @(posedge clk_i);
        check(32'(mux), 32'hb);
        ce <= 1'b1;
        diff <= 1'b0;
        $display("test basic done");
    endtask : t_basic
    task automatic t_sw();
        int n;
        logic [7:0] m [2] = '{8'h00, 8'hfd};
        op(1'b1, 4'hb, 8'hf9);
        n = nstart;
        op(1'b1, 4'hc, 8'h37);
        repeat (10) @(posedge clk_i);
        check(32'(nstart - n), 32'h1);
        op(1'b0, 4'h8, 8'h00);
        check(32'(rd_q[12]), 32'h0);
        op(1'b0, 4'h4, 8'h00);
        check(32'(rd_q[15:8]), 32'h5a);
        op(1'b0, 4'h5, 8'h00);
        check(32'(rd_q[15:8]), 32'ha5);
        foreach (m[i]) begin
            op(1'b1, 4'hb, m[i]);
            n = nstart;
            op(1'b1, 4'hc, 8'h00);
            repeat (10) @(posedge clk_i);
            check(32'(nstart - n), 32'h0);
        end
        $display("test software trigger done");
    endtask : t_sw
    task automatic t_pacer();
        int n;
        int s;
        wb(1'b1, 8'h0c, 32'hf);
        op(1'b1, 4'hb, 8'h06);
        kick(1'b0);
        check(32'({io_c.irq, irq_o}), 32'h3);
        wb(1'b1, 8'h0c, 32'h0);
        repeat (2) @(posedge clk_i);
        check(32'(irq_o), 32'h0);
        op(1'b1, 4'h8, 8'h99);
        repeat (2) @(posedge clk_i);
        check(32'(io_c.irq), 32'h0);
        wb(1'b0, 8'h08, 32'h0);
        check(32'(rd_q[1]), 32'h1);
        wb(1'b1, 8'h08, 32'hf);
        wb(1'b0, 8'h08, 32'h0);
        check(rd_q, 32'h0);
        op(1'b1, 4'hb, 8'h02);
        n = ndma;
        s = nstart;
        kick(1'b0);
        check(32'(ndma - n), 32'h2);
        op(1'b1, 4'hc, 8'h00);
        repeat (10) @(posedge clk_i);
        check(32'(nstart - s), 32'h1);
        $display("test pacer done");
    endtask : t_pacer
    task automatic t_ext();
        int n;
        logic [7:0] m [4] = '{8'h02, 8'h06, 8'h01, 8'h00};
        logic [3:0] e = 4'b0011;
        jmp <= 1'b1;
        foreach (m[i]) begin
            op(1'b1, 4'hb, m[i]);
            n = nstart;
            kick(1'b1);
            check(32'(nstart - n), 32'(e[i]));
        end
        jmp <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            rsp <= i == 0;
            wb(1'b1, 8'h08, 32'hf);
            wb(1'b1, 8'h00, 32'h0002_0000);
            repeat (100) @(posedge clk_i);
            idle();
            wb(1'b0, 8'h08, 32'h0);
            check(32'(rd_q[3:2]), (i == 0) ? 32'h2 : 32'h1);
        end
        $display("test external and detect done");
    endtask : t_ext
    task automatic end_sim();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_basic();
        t_sw();
        t_pacer();
        t_ext();
        end_sim();
    end
endmodule : atc_tb_top
`default_nettype wire
